// file: tb/cpoc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpoc_flash_model (
   input wire logic link_clk,
   input wire logic flash_select_n,
   input wire logic flash_clk_en,
   input wire logic [31:0] ctrl_word,
   input wire logic [31:0] opt_word,
   output logic flash_line1
);
   logic [95:0] image;
   int idx = 0;
   // padding ones, start word, control word, option word, msb first
   assign image = {16'hFFFF, 16'hBDB3, ctrl_word, opt_word};
   // ----------------
   // serial output
   // ----------------
   // bits move on the falling edge; deselected or past the end the line
   // keeps flipping so a stale bit can never pass for data
   initial flash_line1 = 1'b0;
   always @(negedge link_clk) begin
      if (flash_select_n) begin
         idx <= 0;
         flash_line1 <= ~flash_line1;
      end else if (flash_clk_en) begin
         flash_line1 <= (idx < 96) ? image[95 - idx] : ~flash_line1;
         idx <= idx + 1;
      end
   end
endmodule : cpoc_flash_model
`default_nettype wire

// file: tb/cpoc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cpoc_top_monitor (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic refresh_cmd,
   input wire logic done_pin_i,
   input wire logic done_pin_oe,
   input wire logic rdbk_req,
   input wire logic [1:0] rdbk_region,
   input wire logic rdbk_via_i2c,
   input wire logic rdbk_grant,
   input wire logic rdbk_refuse,
   input wire logic [5:0] mspi_attach,
   input wire logic i2c_attach,
   input wire logic jtag_attach,
   input wire logic done_attach,
   input wire logic user_mode,
   input wire logic [1:0] access_mode,
   input wire logic wr_sram,
   input wire logic wr_ebr,
   input wire logic wr_ip,
   input wire logic wake_done_sync,
   input wire logic [2:0] flash_clock_rate_sel,
   input wire logic [17:0] flash_clock_rate_khz,
   input wire logic readback_lock
);
   // own copy of the rate table, so a slip in the design's copy shows up
   localparam logic [17:0] KHZ [8] = '{18'h00DAC, 18'h01B58, 18'h03714, 18'h06DC4,
                                       18'h0DB88, 18'h15F90, 18'h1B774, 18'h249F0};
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // ----------------
   // pins and modes
   // ----------------
   idle_attach_a: assert property (
      !user_mode |-> mspi_attach == 6'h3F && i2c_attach && jtag_attach && done_attach)
      else $error("pin released outside user mode");
   mspi_group_a: assert property (user_mode |-> mspi_attach inside {6'h00, 6'h0F, 6'h3F})
      else $error("master port pins split wrongly");
   done_free_a: assert property (!done_attach |-> !done_pin_oe)
      else $error("freed done pin still driven");
   write_mask_a: assert property (
      wr_sram && wr_ebr == (access_mode != 2'h3) && wr_ip == !access_mode[1])
      else $error("write enables do not match access mode");
   refresh_leave_a: assert property (user_mode && refresh_cmd && ce |=> !user_mode)
      else $error("refresh did not leave user mode");
   reprog_clear_a: assert property (
      $fell(user_mode) |-> !readback_lock && flash_clock_rate_sel == 3'h0)
      else $error("lock or rate kept across reprogramming");
   ext_done_a: assert property ($rose(user_mode) && wake_done_sync |-> $past(done_pin_i, 2))
      else $error("woke before external done pin went high");
   rate_table_a: assert property (flash_clock_rate_khz == KHZ[flash_clock_rate_sel])
      else $error("flash clock rate does not match its code");
   // ----------------
   // readback answers
   // ----------------
   lock_refuse_a: assert property (
      rdbk_req && readback_lock && rdbk_region == 2'h0 |=> rdbk_refuse && !rdbk_grant)
      else $error("locked sram readback not refused");
   i2c_refuse_a: assert property (
      rdbk_req && rdbk_via_i2c && (rdbk_region != 2'h0 || !i2c_attach) |=> rdbk_refuse)
      else $error("two-wire readback of ram not refused");
   open_grant_a: assert property (
      rdbk_req && !readback_lock && !rdbk_via_i2c |=> rdbk_grant && !rdbk_refuse)
      else $error("unlocked readback not granted");
   no_answer_a: assert property (!rdbk_req |=> !rdbk_grant && !rdbk_refuse)
      else $error("readback answer without request");
endmodule : cpoc_top_monitor
bind cpoc_top cpoc_top_monitor mon (.clk, .srst, .ce, .refresh_cmd, .done_pin_i, .done_pin_oe, .rdbk_req,
   .rdbk_region, .rdbk_via_i2c, .rdbk_grant, .rdbk_refuse, .mspi_attach, .i2c_attach, .jtag_attach,
   .done_attach, .user_mode, .access_mode, .wr_sram, .wr_ebr, .wr_ip, .wake_done_sync,
   .flash_clock_rate_sel, .flash_clock_rate_khz, .readback_lock);
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [17:0] KHZ [8] = '{18'h00DAC, 18'h01B58, 18'h03714, 18'h06DC4,
                                       18'h0DB88, 18'h15F90, 18'h1B774, 18'h249F0};
   logic clk = 1'b0, link_clk = 1'b0, srst = 1'b1, ce = 1'b1, ext_low = 1'b1;
   logic cfg_start = 1'b0, cfg_done_bit = 1'b0, refresh_cmd = 1'b0, program_request_pin_i = 1'b1;
   logic slave_spi_keep = 1'b0, slave_spi_quad_keep = 1'b0, rdbk_req = 1'b0, rdbk_via_i2c = 1'b0;
   logic [1:0] rdbk_region = 2'h0;
   logic done_pin_i, flash_line1, flash_select_n, flash_clk_en, done_pin_o, done_pin_oe, init_status_pin_o;
   logic init_status_pin_oe, rdbk_grant, rdbk_refuse, i2c_attach, jtag_attach, done_attach, init_attach;
   logic prog_attach, user_mode, wr_sram, wr_ebr, wr_ip, wake_done_sync, readback_lock;
   logic [5:0] mspi_attach;
   logic [1:0] access_mode;
   logic [2:0] flash_clock_rate_sel;
   logic [17:0] flash_clock_rate_khz;
   logic [31:0] ctrl_word = 32'h0, opt_word = 32'h0;
   int bad_count = 0, checked = 0;
   // ----------------
   // clocks and board
   // ----------------
   always #2.5 clk = ~clk;
   // link clock offset so its edges never line up with clk
   initial begin
      #3.3;
      forever #80 link_clk = ~link_clk;
   end
   // pull-up on the done line; the board or the device may hold it low
   assign done_pin_i = ~ext_low & ~(done_pin_oe & ~done_pin_o);
   cpoc_top uut (.clk, .srst, .ce, .link_clk, .flash_line1, .flash_select_n, .flash_clk_en, .cfg_start,
      .cfg_done_bit, .refresh_cmd, .program_request_pin_i, .done_pin_i, .done_pin_o, .done_pin_oe,
      .init_status_pin_o, .init_status_pin_oe, .slave_spi_keep, .slave_spi_quad_keep, .rdbk_req,
      .rdbk_region, .rdbk_via_i2c, .rdbk_grant, .rdbk_refuse, .mspi_attach, .i2c_attach, .jtag_attach,
      .done_attach, .init_attach, .prog_attach, .user_mode, .access_mode, .wr_sram, .wr_ebr, .wr_ip,
      .wake_done_sync, .flash_clock_rate_sel, .flash_clock_rate_khz, .readback_lock);
   cpoc_flash_model flash (.link_clk, .flash_select_n, .flash_clk_en, .ctrl_word, .opt_word, .flash_line1);
   // ----------------
   // expectations
   // ----------------
   function automatic logic [5:0] mspi_exp(input logic [1:0] m);
      return (m == 2'h0) ? 6'h00 : (m == 2'h3) ? 6'h3F : 6'h0F;
   endfunction : mspi_exp
   function automatic logic [2:0] wr_exp(input logic [1:0] m);
      return {1'b1, m != 2'h3, m < 2'h2};
   endfunction : wr_exp
   function automatic logic [1:0] rdbk_exp(input logic [1:0] r, input logic i2c, input logic lock, input logic kept);
      logic refuse;
      refuse = (lock && r == 2'h0) || (i2c && (r != 2'h0 || !kept));
      return {!refuse, refuse};
   endfunction : rdbk_exp
   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // bounded wait; running out shows as a mismatch
   task automatic wait_lvl(ref logic sig, input logic lvl, input string what);
      int k;
      k = 0;
      while (sig !== lvl && k < 8000) begin
         @(negedge clk);
         k++;
      end
      check(what, 18'(lvl), 18'(sig));
   endtask : wait_lvl
   // ----------------
   // one configuration pass
   // ----------------
   task automatic run_config(input int n);
      logic [31:0] old;
      old = opt_word;
      ctrl_word = $urandom();
      ctrl_word[2:0] = n[2:0];
      opt_word = $urandom() & 32'h00000FFF;
      opt_word[1:0] = n[1:0];
      opt_word[8:7] = n[2:1];
      opt_word[6] = n[1];
      opt_word[9] = n[0];
      opt_word[4] = opt_word[4] | n[0];
      slave_spi_keep = 1'($urandom_range(1));
      slave_spi_quad_keep = 1'($urandom_range(1));
      // with external done on, the board must hold the line low until the bench lets go
      ext_low = 1'($urandom_range(1)) | opt_word[9];
      cfg_done_bit = 1'b0;
      // first pass from idle, later ones reconfigure from user mode
      if (!user_mode) begin
         cfg_start = 1'b1;
      end else if (old[6]) begin
         program_request_pin_i = 1'b0;
      end else begin
         refresh_cmd = 1'b1;
      end
      @(negedge clk);
      cfg_start = 1'b0;
      refresh_cmd = 1'b0;
      wait_lvl(flash_select_n, 1'b0, "fetch start");
      program_request_pin_i = 1'b1;
      check("fetch state", 18'({access_mode, wr_sram, wr_ebr, wr_ip, readback_lock, flash_clock_rate_sel}),
            18'({old[8:7], wr_exp(old[8:7]), 1'b0, 3'h0}));
      wait_lvl(flash_select_n, 1'b1, "fetch end");
      repeat (30) @(negedge clk);
      check("wait done bit", 18'h0, 18'(user_mode));
      cfg_done_bit = 1'b1;
      if (opt_word[9]) begin
         repeat (30) @(negedge clk);
         check("wait done pin", 18'h0, 18'(user_mode));
         ext_low = 1'b0;
      end
      wait_lvl(user_mode, 1'b1, "user mode");
      repeat (25) @(negedge clk);
      check("mspi", 18'(mspi_exp(opt_word[1:0])), 18'(mspi_attach));
      check("pins", 18'({opt_word[2] | slave_spi_quad_keep, opt_word[3] | slave_spi_keep, opt_word[6:4]}),
            18'({i2c_attach, jtag_attach, prog_attach, init_attach, done_attach}));
      check("options", 18'({opt_word[9], opt_word[11], ctrl_word[2:0]}),
            18'({wake_done_sync, readback_lock, flash_clock_rate_sel}));
      check("rate khz", KHZ[ctrl_word[2:0]], flash_clock_rate_khz);
      check("done drive", 18'({2{opt_word[4] & ~opt_word[10]}}),
            18'({done_pin_oe, done_pin_oe & done_pin_o}));
      for (int k = 0; k < 6; k++) begin
         rdbk_region = 2'(k / 2);
         rdbk_via_i2c = k[0];
         rdbk_req = 1'b1;
         @(negedge clk);
         rdbk_req = 1'b0;
         check("readback", 18'(rdbk_exp(rdbk_region, rdbk_via_i2c, opt_word[11],
               opt_word[2] | slave_spi_quad_keep)), 18'({rdbk_grant, rdbk_refuse}));
         @(negedge clk);
      end
   endtask : run_config
   task automatic tally_and_finish();
      $display("compares %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------
   // main sequence and watchdog
   // ----------------
   initial begin
      int seed;
      seed = $urandom(3414);
      // reset must also span link edges so the link side sees it
      repeat (3) @(posedge link_clk);
      repeat (3) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      repeat (140) @(negedge clk);
      // unconfigured: init pulled low, done held low through its open drain
      check("idle pins", 18'hA, 18'({init_status_pin_oe, init_status_pin_o, done_pin_oe, done_pin_o}));
      for (int n = 0; n < 8; n++) begin
         run_config(n);
      end
      // a low enable must freeze the options, even against a refresh request
      ce = 1'b0;
      refresh_cmd = 1'b1;
      repeat (4) @(negedge clk);
      check("frozen", 18'h1, 18'(user_mode));
      refresh_cmd = 1'b0;
      ce = 1'b1;
      @(negedge clk);
      tally_and_finish();
   end
   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire

// file: verilog/cpoc_pkg.sv
`default_nettype none
package cpoc_pkg;
   // ----------------------------------------
   // stream framing and word layout
   // ----------------------------------------
   localparam logic [15:0] SYNC_WORD = 16'hBDB3;
   localparam logic [4:0] WORD_LAST = 5'h1F;
   localparam int CTRL_RATE_LSB = 0;
   localparam int OPT_MSPI_LSB = 0;
   localparam int OPT_I2C = 2;
   localparam int OPT_JTAG = 3;
   localparam int OPT_DONEP = 4;
   localparam int OPT_INITP = 5;
   localparam int OPT_PROGP = 6;
   localparam int OPT_BG_LSB = 7;
   localparam int OPT_DONEX = 9;
   localparam int OPT_DONEOD = 10;
   localparam int OPT_LOCK = 11;
   // test, done, init, program ports on; done open-drain
   localparam logic [31:0] OPT_RESET = 32'h00000478;
   localparam logic [2:0] RATE_RESET = 3'h0;
   localparam logic [1:0] MSPI_OFF = 2'h0;
   localparam logic [1:0] MSPI_QUAD = 2'h3;
   localparam logic [1:0] RGN_SRAM = 2'h0;
   localparam logic [5:0] PINS_ALL = 6'h3F;
   localparam logic [5:0] PINS_FOUR = 6'h0F;
   localparam logic [5:0] PINS_NONE = 6'h00;
   // ----------------------------------------
   // flash clock rates in kHz
   // ----------------------------------------
   localparam logic [17:0] RATE_KHZ [8] = '{18'h00DAC, 18'h01B58, 18'h03714, 18'h06DC4,
                                            18'h0DB88, 18'h15F90, 18'h1B774, 18'h249F0};
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SWITCH_DELAY_NS = 100;
   localparam int SWITCH_CYC = (SWITCH_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      ACC_OFFLINE = 2'h0,
      ACC_ALL = 2'h1,
      ACC_TRANSPARENT_SRAM_BLOCKRAM = 2'h2,
      ACC_SRAM = 2'h3
   } cpoc_access_e;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_FETCH = 6'h02,
      S_LOADED = 6'h04,
      S_XWAIT = 6'h08,
      S_WAKE = 6'h10,
      S_USER = 6'h20
   } cpoc_state_e;
   typedef enum logic [4:0] {
      L_IDLE = 5'h01,
      L_HUNT = 5'h02,
      L_CTRL = 5'h04,
      L_OPT = 5'h08,
      L_HOLD = 5'h10
   } cpoc_lstate_e;
endpackage : cpoc_pkg
`default_nettype wire

// file: verilog/cpoc_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpoc_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic link_clk,
   input wire logic flash_line1,
   output logic flash_select_n,
   output logic flash_clk_en,
   input wire logic cfg_start,
   input wire logic cfg_done_bit,
   input wire logic refresh_cmd,
   input wire logic program_request_pin_i,
   input wire logic done_pin_i,
   output logic done_pin_o,
   output logic done_pin_oe,
   output logic init_status_pin_o,
   output logic init_status_pin_oe,
   input wire logic slave_spi_keep,
   input wire logic slave_spi_quad_keep,
   input wire logic rdbk_req,
   input wire logic [1:0] rdbk_region,
   input wire logic rdbk_via_i2c,
   output logic rdbk_grant,
   output logic rdbk_refuse,
   output logic [5:0] mspi_attach,
   output logic i2c_attach,
   output logic jtag_attach,
   output logic done_attach,
   output logic init_attach,
   output logic prog_attach,
   output logic user_mode,
   output logic [1:0] access_mode,
   output logic wr_sram,
   output logic wr_ebr,
   output logic wr_ip,
   output logic wake_done_sync,
   output logic [2:0] flash_clock_rate_sel,
   output logic [17:0] flash_clock_rate_khz,
   output logic readback_lock
);
   // ----------------------------------------
   // link domain: crossings in
   // ----------------------------------------
   logic lrst_s1_q, lrst_q, lce_s1_q, lce_q, lfetch_s1_q, lfetch_q;
   logic ldat_s1_q, ldat_q;
   logic fetch_q;
   // reset, enable and fetch request enter the link clock through two flops
   always_ff @(posedge link_clk) begin
      lrst_s1_q <= srst;
      lrst_q <= lrst_s1_q;
      lce_s1_q <= ce;
      lce_q <= lce_s1_q;
      lfetch_s1_q <= fetch_q;
      lfetch_q <= lfetch_s1_q;
      ldat_s1_q <= flash_line1;
      ldat_q <= ldat_s1_q;
   end

   // ----------------------------------------
   // link domain: stream reader
   // ----------------------------------------
   cpoc_pkg::cpoc_lstate_e l_state_q, l_state_d;
   logic [15:0] l_sr_q, l_sr_d;
   logic [4:0] l_cnt_q, l_cnt_d;
   logic [31:0] l_ctrl_q, l_ctrl_d, l_opt_q, l_opt_d;
   logic l_tgl_q, l_tgl_d, l_seln_q, l_seln_d, l_cken_q, l_cken_d;

   // padding is shifted through until the sync word lines up, then two words follow
   always_comb begin
      l_state_d = l_state_q;
      l_sr_d = l_sr_q;
      l_cnt_d = l_cnt_q;
      l_ctrl_d = l_ctrl_q;
      l_opt_d = l_opt_q;
      l_tgl_d = l_tgl_q;
      l_seln_d = l_seln_q;
      l_cken_d = l_cken_q;
      case (l_state_q)
         cpoc_pkg::L_IDLE: begin
            if (lfetch_q) begin
               l_state_d = cpoc_pkg::L_HUNT;
               l_sr_d = 16'h0000;
               l_seln_d = 1'b0;
               l_cken_d = 1'b1;
            end
         end
         cpoc_pkg::L_HUNT: begin
            l_sr_d = {l_sr_q[14:0], ldat_q};
            if ({l_sr_q[14:0], ldat_q} == cpoc_pkg::SYNC_WORD) begin
               l_state_d = cpoc_pkg::L_CTRL;
               l_cnt_d = 5'h00;
            end
         end
         cpoc_pkg::L_CTRL: begin
            l_ctrl_d = {l_ctrl_q[30:0], ldat_q};
            l_cnt_d = l_cnt_q + 5'h01;
            if (l_cnt_q == cpoc_pkg::WORD_LAST) begin
               l_state_d = cpoc_pkg::L_OPT;
               l_cnt_d = 5'h00;
            end
         end
         cpoc_pkg::L_OPT: begin
            l_opt_d = {l_opt_q[30:0], ldat_q};
            l_cnt_d = l_cnt_q + 5'h01;
            if (l_cnt_q == cpoc_pkg::WORD_LAST) begin
               l_state_d = cpoc_pkg::L_HOLD;
               l_tgl_d = ~l_tgl_q;
               l_seln_d = 1'b1;
               l_cken_d = 1'b0;
            end
         end
         cpoc_pkg::L_HOLD: begin
            // words stay frozen until the other side drops its request
            if (!lfetch_q) begin
               l_state_d = cpoc_pkg::L_IDLE;
            end
         end
         default: begin
            l_state_d = cpoc_pkg::L_IDLE;
         end
      endcase
   end

   // link registers; enable arrives through its own synchroniser
   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         l_state_q <= cpoc_pkg::L_IDLE;
         l_sr_q <= 16'h0000;
         l_cnt_q <= 5'h00;
         l_ctrl_q <= 32'h00000000;
         l_opt_q <= 32'h00000000;
         l_tgl_q <= 1'b0;
         l_seln_q <= 1'b1;
         l_cken_q <= 1'b0;
      end else if (lce_q) begin
         l_state_q <= l_state_d;
         l_sr_q <= l_sr_d;
         l_cnt_q <= l_cnt_d;
         l_ctrl_q <= l_ctrl_d;
         l_opt_q <= l_opt_d;
         l_tgl_q <= l_tgl_d;
         l_seln_q <= l_seln_d;
         l_cken_q <= l_cken_d;
      end
   end
   assign flash_select_n = l_seln_q;
   assign flash_clk_en = l_cken_q;

   // ----------------------------------------
   // system domain: crossings in
   // ----------------------------------------
   logic tgl_s1_q, tgl_s2_q, tgl_s3_q, done_s1_q, done_s2_q, prog_s1_q, prog_s2_q, prog_s3_q;
   // pins and the link toggle pass two flops; the third only feeds edge detection
   always_ff @(posedge clk) begin
      if (srst) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         prog_s1_q <= 1'b1;
         prog_s2_q <= 1'b1;
         prog_s3_q <= 1'b1;
      end else if (ce) begin
         tgl_s1_q <= l_tgl_q;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
         done_s1_q <= done_pin_i;
         done_s2_q <= done_s1_q;
         prog_s1_q <= program_request_pin_i;
         prog_s2_q <= prog_s1_q;
         prog_s3_q <= prog_s2_q;
      end
   end
   wire logic words_in = tgl_s2_q ^ tgl_s3_q;
   wire logic prog_fall = prog_s3_q & ~prog_s2_q;

   // ----------------------------------------
   // system domain: sequencer and options
   // ----------------------------------------
   cpoc_pkg::cpoc_state_e state_q, state_d;
   logic [31:0] opt_q, opt_d, stage_q, stage_d;
   logic [1:0] acc_q, acc_d;
   logic lock_q, lock_d, fetch_d;
   logic [2:0] rate_q, rate_d, rpend_q, rpend_d;
   logic [7:0] rcnt_q, rcnt_d;
   logic rarm_q, rarm_d;
   localparam logic [7:0] SW_CYC = 8'(cpoc_pkg::SWITCH_CYC);

   // map a background option to the access mode of the next reconfiguration
   function automatic logic [1:0] bg_to_acc(input logic [1:0] bg);
      case (bg)
         2'h1: bg_to_acc = cpoc_pkg::ACC_ALL;
         2'h2: bg_to_acc = cpoc_pkg::ACC_TRANSPARENT_SRAM_BLOCKRAM;
         2'h3: bg_to_acc = cpoc_pkg::ACC_SRAM;
         default: bg_to_acc = cpoc_pkg::ACC_OFFLINE;
      endcase
   endfunction : bg_to_acc

   // program pin counts as a request only in user mode, and only while its port is retained
   wire logic prog_live = (state_q != cpoc_pkg::S_USER) | opt_q[cpoc_pkg::OPT_PROGP];
   wire logic reconfig = refresh_cmd | (prog_live & prog_fall);

   always_comb begin
      state_d = state_q;
      opt_d = opt_q;
      stage_d = stage_q;
      acc_d = acc_q;
      lock_d = lock_q;
      fetch_d = fetch_q;
      rate_d = rate_q;
      rpend_d = rpend_q;
      rcnt_d = rcnt_q;
      rarm_d = rarm_q;
      // rate switch waits a fixed short delay after the setting lands
      if (rarm_q) begin
         if (rcnt_q == SW_CYC - 8'h01) begin
            rate_d = rpend_q;
            rarm_d = 1'b0;
         end else begin
            rcnt_d = rcnt_q + 8'h01;
         end
      end
      case (state_q)
         cpoc_pkg::S_IDLE: begin
            if (cfg_start) begin
               state_d = cpoc_pkg::S_FETCH;
               fetch_d = 1'b1;
               rate_d = cpoc_pkg::RATE_RESET;
               lock_d = 1'b0;
            end
         end
         cpoc_pkg::S_FETCH: begin
            if (words_in) begin
               state_d = cpoc_pkg::S_LOADED;
               fetch_d = 1'b0;
               stage_d = l_opt_q;
               rpend_d = l_ctrl_q[cpoc_pkg::CTRL_RATE_LSB +: 3];
               rcnt_d = 8'h00;
               rarm_d = 1'b1;
            end
         end
         cpoc_pkg::S_LOADED: begin
            if (cfg_done_bit) begin
               if (stage_q[cpoc_pkg::OPT_DONEX]) begin
                  state_d = cpoc_pkg::S_XWAIT;
               end else begin
                  state_d = cpoc_pkg::S_WAKE;
               end
            end
         end
         cpoc_pkg::S_XWAIT: begin
            if (done_s2_q) begin
               state_d = cpoc_pkg::S_WAKE;
            end
         end
         cpoc_pkg::S_WAKE: begin
            state_d = cpoc_pkg::S_USER;
            opt_d = stage_q;
            lock_d = stage_q[cpoc_pkg::OPT_LOCK];
         end
         cpoc_pkg::S_USER: begin
            if (reconfig) begin
               state_d = cpoc_pkg::S_FETCH;
               fetch_d = 1'b1;
               acc_d = bg_to_acc(opt_q[cpoc_pkg::OPT_BG_LSB +: 2]);
               rate_d = cpoc_pkg::RATE_RESET;
               rarm_d = 1'b0;
               lock_d = 1'b0;
            end
         end
         default: begin
            state_d = cpoc_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= cpoc_pkg::S_IDLE;
         opt_q <= cpoc_pkg::OPT_RESET;
         stage_q <= cpoc_pkg::OPT_RESET;
         acc_q <= cpoc_pkg::ACC_OFFLINE;
         lock_q <= 1'b0;
         fetch_q <= 1'b0;
         rate_q <= cpoc_pkg::RATE_RESET;
         rpend_q <= cpoc_pkg::RATE_RESET;
         rcnt_q <= 8'h00;
         rarm_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         opt_q <= opt_d;
         stage_q <= stage_d;
         acc_q <= acc_d;
         lock_q <= lock_d;
         fetch_q <= fetch_d;
         rate_q <= rate_d;
         rpend_q <= rpend_d;
         rcnt_q <= rcnt_d;
         rarm_q <= rarm_d;
      end
   end

   // ----------------------------------------
   // system domain: pin ownership and outputs
   // ----------------------------------------
   logic [5:0] mspi_d;
   logic i2c_d, jtag_d, donea_d, inita_d, proga_d, user_d, donehi, done_o_d, done_oe_d, init_oe_d;
   logic wsram_d, webr_d, wip_d, refuse_d, grant_d;

   // outside user mode every configuration pin belongs to the loader
   always_comb begin
      user_d = (state_d == cpoc_pkg::S_USER);
      mspi_d = cpoc_pkg::PINS_ALL;
      i2c_d = 1'b1;
      jtag_d = 1'b1;
      donea_d = 1'b1;
      inita_d = 1'b1;
      proga_d = 1'b1;
      if (user_d) begin
         if (opt_d[cpoc_pkg::OPT_MSPI_LSB +: 2] == cpoc_pkg::MSPI_OFF) begin
            mspi_d = cpoc_pkg::PINS_NONE;
         end else if (opt_d[cpoc_pkg::OPT_MSPI_LSB +: 2] == cpoc_pkg::MSPI_QUAD) begin
            mspi_d = cpoc_pkg::PINS_ALL;
         end else begin
            mspi_d = cpoc_pkg::PINS_FOUR;
         end
         i2c_d = opt_d[cpoc_pkg::OPT_I2C] | slave_spi_quad_keep;
         jtag_d = opt_d[cpoc_pkg::OPT_JTAG] | slave_spi_keep;
         donea_d = opt_d[cpoc_pkg::OPT_DONEP];
         inita_d = opt_d[cpoc_pkg::OPT_INITP];
         proga_d = opt_d[cpoc_pkg::OPT_PROGP];
      end
      // done released early for external sync, otherwise only once awake
      donehi = (state_d == cpoc_pkg::S_XWAIT) | user_d;
      if (user_d ? opt_d[cpoc_pkg::OPT_DONEOD] : stage_d[cpoc_pkg::OPT_DONEOD]) begin
         done_o_d = 1'b0;
         done_oe_d = donea_d & ~donehi;
      end else begin
         done_o_d = donehi;
         done_oe_d = donea_d;
      end
      init_oe_d = inita_d & (state_d == cpoc_pkg::S_IDLE);
      wsram_d = 1'b1;
      webr_d = (acc_d != cpoc_pkg::ACC_SRAM);
      wip_d = (acc_d == cpoc_pkg::ACC_OFFLINE) | (acc_d == cpoc_pkg::ACC_ALL);
      // readback refusals: lock bars sram, the two-wire port reads only sram and only while it is attached
      refuse_d = rdbk_req & ((lock_d & (rdbk_region == cpoc_pkg::RGN_SRAM))
                 | (rdbk_via_i2c & ((rdbk_region != cpoc_pkg::RGN_SRAM) | ~i2c_d)));
      grant_d = rdbk_req & ~refuse_d;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mspi_attach <= cpoc_pkg::PINS_ALL;
         i2c_attach <= 1'b1;
         jtag_attach <= 1'b1;
         done_attach <= 1'b1;
         init_attach <= 1'b1;
         prog_attach <= 1'b1;
         user_mode <= 1'b0;
         done_pin_o <= 1'b0;
         done_pin_oe <= 1'b1;
         init_status_pin_o <= 1'b0;
         init_status_pin_oe <= 1'b1;
         access_mode <= cpoc_pkg::ACC_OFFLINE;
         wr_sram <= 1'b1;
         wr_ebr <= 1'b1;
         wr_ip <= 1'b1;
         wake_done_sync <= 1'b0;
         flash_clock_rate_sel <= cpoc_pkg::RATE_RESET;
         flash_clock_rate_khz <= cpoc_pkg::RATE_KHZ[cpoc_pkg::RATE_RESET];
         readback_lock <= 1'b0;
         rdbk_grant <= 1'b0;
         rdbk_refuse <= 1'b0;
      end else if (ce) begin
         mspi_attach <= mspi_d;
         i2c_attach <= i2c_d;
         jtag_attach <= jtag_d;
         done_attach <= donea_d;
         init_attach <= inita_d;
         prog_attach <= proga_d;
         user_mode <= user_d;
         done_pin_o <= done_o_d;
         done_pin_oe <= done_oe_d;
         init_status_pin_o <= 1'b0;
         init_status_pin_oe <= init_oe_d;
         access_mode <= acc_d;
         wr_sram <= wsram_d;
         wr_ebr <= webr_d;
         wr_ip <= wip_d;
         wake_done_sync <= stage_d[cpoc_pkg::OPT_DONEX];
         flash_clock_rate_sel <= rate_d;
         flash_clock_rate_khz <= cpoc_pkg::RATE_KHZ[rate_d];
         readback_lock <= lock_d;
         rdbk_grant <= grant_d;
         rdbk_refuse <= refuse_d;
      end
   end
endmodule : cpoc_top
`default_nettype wire
